/* common/iop_pkg.sv */
package iop_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int WORD_W = 12;
  localparam int ACC_W  = 18;
  localparam int FLD_W  = 6;

  // ****************************************************************
  // opcode values (upper six bits of an instruction word)
  // ****************************************************************
  localparam logic [5:0] OP_PASS   = 6'h00;
  localparam logic [5:0] OP_LJM    = 6'h01;  // long jump
  localparam logic [5:0] OP_RJM    = 6'h02;  // return jump
  localparam logic [5:0] OP_UJN    = 6'h03;  // unconditional relative
  localparam logic [5:0] OP_ZJN    = 6'h04;
  localparam logic [5:0] OP_NJN    = 6'h05;
  localparam logic [5:0] OP_PJN    = 6'h06;
  localparam logic [5:0] OP_MJN    = 6'h07;
  localparam logic [5:0] OP_SHIFT  = 6'h08;  // octal 10
  localparam logic [5:0] OP_LDIFF  = 6'h09;  // octal 11
  localparam logic [5:0] OP_LPROD  = 6'h0A;  // octal 12
  localparam logic [5:0] OP_SCLR   = 6'h0B;  // octal 13
  localparam logic [5:0] OP_LDI    = 6'h0C;  // octal 14
  localparam logic [5:0] OP_LDL    = 6'h10;  // octal 20
  localparam logic [2:0] GRP_DIR   = 3'h3;   // octal 30-37
  localparam logic [2:0] GRP_IND   = 3'h4;   // octal 40-47
  localparam logic [2:0] GRP_IDX   = 3'h5;   // octal 50-57
  localparam logic [2:0] GRP_LOAD  = 3'h0;   // low digit of a load

  // ****************************************************************
  // field values and constants
  // ****************************************************************
  localparam logic [5:0]  D_ZERO    = 6'h00;
  localparam logic [5:0]  D_ONES    = 6'h3F;  // octal 77
  localparam logic [11:0] STEP_ONE  = 12'h001;
  localparam logic [11:0] STEP_TWO  = 12'h002;
  localparam logic [11:0] PC_RESET  = 12'h000;
  localparam logic [17:0] ACC_RESET = 18'h00000;
  localparam logic [17:0] ACC_POS0  = 18'h00000;
  localparam int          SIGN_BIT  = 17;
  localparam int          SH_DIR    = 5;      // count bit that means right

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [8:0] {
    S_FETCH = 9'h001,
    S_WAIT  = 9'h002,
    S_DEC   = 9'h004,
    S_EXT   = 9'h008,
    S_INDEX = 9'h010,
    S_ADDR  = 9'h020,
    S_IND   = 9'h040,
    S_OPER  = 9'h080,
    S_HANG  = 9'h100
  } state_t;

endpackage : iop_pkg

/* verilog/io_processor_decode.sv */
`timescale 1ns/10ps

// Operation
// - immediate d zero-extended; long is d over m
// - short direct reaches words 0000 to 0077
// - long address m plus (d) if d nonzero
// - indirect reads d, uses word as address
// - unused instruction bits are ignored
// - opcode 0000 only advances program counter
// - long jump to m plus (d)
// - return jump stores P+2, resumes target+1
// - relative jump adds sign-extended offset
// - taken jump with offset 00 or 77 hangs until restart
// - zero jump only on positive zero
// - nonzero jump on anything but positive zero
// - plus jump when sign bit clear
// - minus jump when sign bit set
// - count 00-37 rotates accumulator left
// - count 40-77 shifts right by complement
// - immediate xor into low six bits
// - immediate and, upper twelve bits zeroed
// - selective clear of low six bits
// - immediate load, upper twelve bits zero
// - opcode upper six bits, d lower six
// - extension word fetched from P+1
module io_processor_decode (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic [iop_pkg::WORD_W-1:0] mem_rdata,
  output logic      [iop_pkg::WORD_W-1:0] mem_addr,
  output logic                            mem_rd,
  output logic                            mem_wr,
  output logic      [iop_pkg::WORD_W-1:0] mem_wdata,
  output logic      [iop_pkg::WORD_W-1:0] pc,
  output logic      [iop_pkg::ACC_W-1:0]  acc,
  output logic      [iop_pkg::WORD_W-1:0] oper_addr,
  output logic      [iop_pkg::WORD_W-1:0] oper_data,
  output logic                            oper_valid,
  output logic                            hung
);
  import iop_pkg::*;

  // ****************************************************************
  // state record
  // ****************************************************************
  typedef struct packed {
    state_t              state;
    state_t              ret;        // state after a memory read
    logic [WORD_W-1:0]   pc;
    logic [ACC_W-1:0]    acc;
    logic [WORD_W-1:0]   ir;
    logic [WORD_W-1:0]   ext;
    logic [WORD_W-1:0]   idx;
    logic [WORD_W-1:0]   mem_addr;
    logic                mem_rd;
    logic                mem_wr;
    logic [WORD_W-1:0]   mem_wdata;
    logic [WORD_W-1:0]   oper_addr;
    logic [WORD_W-1:0]   oper_data;
    logic                oper_valid;
    logic                hung;
  } core_t;

  core_t core_reg;
  core_t core_next;

  // ****************************************************************
  // helpers
  // ****************************************************************

  function automatic logic [WORD_W-1:0] rel_off(input logic [5:0] d);
    rel_off = {{(WORD_W-FLD_W){d[FLD_W-1]}}, d};
  endfunction : rel_off

  // circular left, end-off right by complement
  function automatic logic [ACC_W-1:0] shift_acc(
    input logic [ACC_W-1:0] a,
    input logic [5:0]       d
  );
    logic [ACC_W-1:0] r;
    r = a;
    if (d[SH_DIR])
    begin
      r = a >> (~d);
    end
    else
    begin
      for (int i = 0; i < 2**(FLD_W-1); i++)
      begin
        if (i < int'(d))
        begin
          r = {r[ACC_W-2:0], r[ACC_W-1]};
        end
      end
    end
    shift_acc = r;
  endfunction : shift_acc

  function automatic logic jump_taken(
    input logic [5:0]       op,
    input logic [ACC_W-1:0] a
  );
    logic t;
    t = 1'b0;
    unique case (op)
      OP_UJN:  t = 1'b1;
      OP_ZJN:  t = (a == ACC_POS0);
      OP_NJN:  t = (a != ACC_POS0);
      OP_PJN:  t = ~a[SIGN_BIT];
      OP_MJN:  t = a[SIGN_BIT];
      default: t = 1'b0;
    endcase
    jump_taken = t;
  endfunction : jump_taken

  // opcode is in the given memory-reference group
  function automatic logic is_mref(input logic [5:0] op,
                                   input logic [2:0] grp);
    is_mref = (op[5:3] == grp);
  endfunction : is_mref

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  logic [5:0]        f_new;
  logic [5:0]        d_new;
  logic [5:0]        f_cur;
  logic [5:0]        d_cur;
  logic [WORD_W-1:0] target;

  // split instruction into opcode and d
  assign f_new  = mem_rdata[11:6];
  assign d_new  = mem_rdata[5:0];
  assign f_cur  = core_reg.ir[11:6];
  assign d_cur  = core_reg.ir[5:0];
  // 12-bit wrapping sum of m and (d)
  assign target = core_reg.ext + core_reg.idx;

  // one transition per cycle; memory read data returns after S_WAIT
  always_comb
  begin
    core_next            = core_reg;
    core_next.mem_rd     = 1'b0;
    core_next.mem_wr     = 1'b0;
    core_next.oper_valid = 1'b0;
    unique case (core_reg.state)
      S_FETCH:
      begin
        core_next.mem_addr = core_reg.pc;
        core_next.mem_rd   = 1'b1;
        core_next.ret      = S_DEC;
        core_next.state    = S_WAIT;
      end
      S_WAIT:
      begin
        core_next.state = core_reg.ret;
      end
      S_DEC:
      begin
        core_next.ir    = mem_rdata;
        core_next.state = S_FETCH;
        if (f_new == OP_LJM || f_new == OP_RJM || f_new == OP_LDL ||
            is_mref(f_new, GRP_IDX))
        begin
          core_next.mem_addr = core_reg.pc + STEP_ONE;
          core_next.mem_rd   = 1'b1;
          core_next.ret      = S_EXT;
          core_next.state    = S_WAIT;
        end
        else if (is_mref(f_new, GRP_DIR))
        begin
          // short direct address limited to low 64 words
          core_next.oper_addr = {{(WORD_W-FLD_W){1'b0}}, d_new};
          core_next.mem_addr  = {{(WORD_W-FLD_W){1'b0}}, d_new};
          core_next.mem_rd    = 1'b1;
          core_next.ret       = S_OPER;
          core_next.state     = S_WAIT;
        end
        else if (is_mref(f_new, GRP_IND))
        begin
          // first read fetches the pointer at d
          core_next.mem_addr = {{(WORD_W-FLD_W){1'b0}}, d_new};
          core_next.mem_rd   = 1'b1;
          core_next.ret      = S_IND;
          core_next.state    = S_WAIT;
        end
        else if (f_new >= OP_UJN && f_new <= OP_MJN)
        begin
          if (jump_taken(f_new, core_reg.acc))
          begin
            // offset 00 or 77 locks the sequencer
            if (d_new == D_ZERO || d_new == D_ONES)
            begin
              core_next.hung  = 1'b1;
              core_next.state = S_HANG;
            end
            else
            begin
              core_next.pc = core_reg.pc + rel_off(d_new);
            end
          end
          else
          begin
            core_next.pc = core_reg.pc + STEP_ONE;
          end
        end
        else
        begin
          // pass and unhandled codes only step P
          core_next.pc = core_reg.pc + STEP_ONE;
          unique case (f_new)
            OP_SHIFT: core_next.acc = shift_acc(core_reg.acc, d_new);
            OP_LDIFF: core_next.acc = {core_reg.acc[ACC_W-1:FLD_W],
                                       core_reg.acc[FLD_W-1:0] ^ d_new};
            // and low six bits, clear the rest
            OP_LPROD: core_next.acc = {{(ACC_W-FLD_W){1'b0}},
                                       core_reg.acc[FLD_W-1:0] & d_new};
            // clear low bits selected by d
            OP_SCLR:  core_next.acc = {core_reg.acc[ACC_W-1:FLD_W],
                                       core_reg.acc[FLD_W-1:0] & ~d_new};
            OP_LDI:   core_next.acc = {{(ACC_W-FLD_W){1'b0}}, d_new};
            default:  core_next.acc = core_reg.acc;
          endcase
        end
      end
      S_EXT:
      begin
        core_next.ext = mem_rdata;
        core_next.idx = '0;
        core_next.state = S_ADDR;
        // index word read only for nonzero d
        if (d_cur != D_ZERO && f_cur != OP_LDL)
        begin
          core_next.mem_addr = {{(WORD_W-FLD_W){1'b0}}, d_cur};
          core_next.mem_rd   = 1'b1;
          core_next.ret      = S_INDEX;
          core_next.state    = S_WAIT;
        end
      end
      S_INDEX:
      begin
        core_next.idx   = mem_rdata;
        core_next.state = S_ADDR;
      end
      S_ADDR:
      begin
        core_next.state = S_FETCH;
        unique case (f_cur)
          OP_LJM: core_next.pc = target;
          OP_RJM:
          begin
            // link word P+2 at target, resume at target+1
            core_next.mem_addr  = target;
            core_next.mem_wdata = core_reg.pc + STEP_TWO;
            core_next.mem_wr    = 1'b1;
            core_next.pc        = target + STEP_ONE;
          end
          OP_LDL:
          begin
            core_next.acc = {d_cur, core_reg.ext};
            core_next.pc  = core_reg.pc + STEP_TWO;
          end
          default:
          begin
            core_next.oper_addr = target;
            core_next.mem_addr  = target;
            core_next.mem_rd    = 1'b1;
            core_next.ret       = S_OPER;
            core_next.state     = S_WAIT;
          end
        endcase
      end
      S_IND:
      begin
        core_next.oper_addr = mem_rdata;
        core_next.mem_addr  = mem_rdata;
        core_next.mem_rd    = 1'b1;
        core_next.ret       = S_OPER;
        core_next.state     = S_WAIT;
      end
      S_OPER:
      begin
        core_next.oper_data  = mem_rdata;
        core_next.oper_valid = 1'b1;
        core_next.state      = S_FETCH;
        core_next.pc         = core_reg.pc +
                               (is_mref(f_cur, GRP_IDX) ? STEP_TWO : STEP_ONE);
        // load variants place the 12-bit operand, upper bits zero
        if (f_cur[2:0] == GRP_LOAD)
        begin
          core_next.acc = {{(ACC_W-WORD_W){1'b0}}, mem_rdata};
        end
      end
      S_HANG:
      begin
        core_next.state = S_HANG;
      end
      default:
      begin
        core_next.state = S_FETCH;
      end
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************

  // synchronous reset clears P and accumulator
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      core_reg            <= '0;
      core_reg.state      <= S_FETCH;
      core_reg.ret        <= S_FETCH;
      core_reg.pc         <= PC_RESET;
      core_reg.acc        <= ACC_RESET;
    end
    else
    begin
      core_reg <= core_next;
    end
  end

  // outputs taken straight from the record
  assign mem_addr   = core_reg.mem_addr;
  assign mem_rd     = core_reg.mem_rd;
  assign mem_wr     = core_reg.mem_wr;
  assign mem_wdata  = core_reg.mem_wdata;
  assign pc         = core_reg.pc;
  assign acc        = core_reg.acc;
  assign oper_addr  = core_reg.oper_addr;
  assign oper_data  = core_reg.oper_data;
  assign oper_valid = core_reg.oper_valid;
  assign hung       = core_reg.hung;

endmodule : io_processor_decode

/* verification/io_processor_decode_assertions.sv */
`timescale 1ns/10ps

// ****************************************************************
// port checker
// ****************************************************************
module io_processor_decode_assertions
  import iop_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       rstn,
  input wire logic [iop_pkg::WORD_W-1:0] mem_rdata,
  input wire logic [iop_pkg::WORD_W-1:0] mem_addr,
  input wire logic                       mem_rd,
  input wire logic                       mem_wr,
  input wire logic [iop_pkg::WORD_W-1:0] mem_wdata,
  input wire logic [iop_pkg::WORD_W-1:0] pc,
  input wire logic [iop_pkg::ACC_W-1:0]  acc,
  input wire logic [iop_pkg::WORD_W-1:0] oper_addr,
  input wire logic [iop_pkg::WORD_W-1:0] oper_data,
  input wire logic                       oper_valid,
  input wire logic                       hung
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // instruction word fetched from P with a given opcode
  sequence fetch_s(logic [5:0] op);
    mem_rd && mem_addr == pc ##1 mem_rdata[11:6] == op;
  endsequence

  pass_step_a: assert property (fetch_s(OP_PASS) |=>
    pc == $past(pc) + STEP_ONE && $stable(acc)) else $error("pass step");
  load_imm_a: assert property (fetch_s(OP_LDI) |=>
    acc == {12'h000, $past(mem_rdata[5:0])}) else $error("load imm");
  diff_imm_a: assert property (fetch_s(OP_LDIFF) |=>
    acc == {$past(acc[17:6]), $past(acc[5:0]) ^ $past(mem_rdata[5:0])})
    else $error("logical difference");
  prod_imm_a: assert property (fetch_s(OP_LPROD) |=>
    acc == {12'h000, $past(acc[5:0]) & $past(mem_rdata[5:0])})
    else $error("logical product");
  zero_skip_a: assert property ((fetch_s(OP_ZJN) ##0 acc != ACC_POS0)
    |=> pc == $past(pc) + STEP_ONE) else $error("zero jump taken");
  minus_skip_a: assert property ((fetch_s(OP_MJN) ##0 !acc[SIGN_BIT])
    |=> pc == $past(pc) + STEP_ONE) else $error("minus jump taken");
  read_gap_a: assert property (mem_rd |=> !mem_rd)
    else $error("reads too close");
  hung_freeze_a: assert property (hung |=> hung && $stable(pc)
    && !mem_rd && !mem_wr) else $error("hang not held");
  hang_entry_a: assert property ((fetch_s(OP_UJN) ##0
    (mem_rdata[5:0] == D_ZERO || mem_rdata[5:0] == D_ONES)) |=> hung)
    else $error("hang not entered");
  ret_store_a: assert property (mem_wr |-> pc == mem_addr + STEP_ONE)
    else $error("return store place");
endmodule : io_processor_decode_assertions

bind io_processor_decode io_processor_decode_assertions chk_u (
  .clk(clk), .rstn(rstn), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
  .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .pc(pc),
  .acc(acc), .oper_addr(oper_addr), .oper_data(oper_data),
  .oper_valid(oper_valid), .hung(hung));

/* verification/io_memory_model.sv */
`timescale 1ns/10ps

// ****************************************************************
// local processor memory, one-cycle read, no stall
// ****************************************************************
module io_memory_model
  import iop_pkg::*;
(
  input wire logic                       clk,
  input wire logic [iop_pkg::WORD_W-1:0] mem_addr,
  input wire logic                       mem_rd,
  input wire logic                       mem_wr,
  input wire logic [iop_pkg::WORD_W-1:0] mem_wdata,
  output logic     [iop_pkg::WORD_W-1:0] mem_rdata
);
  logic [WORD_W-1:0] store [0:4095];
  logic              rd_reg   = 1'b0;
  logic [WORD_W-1:0] last_reg = '0;

  // write on strobe, remember the read strobe and the bus value
  always @(posedge clk)
  begin
    if (mem_wr)
      store[mem_addr] <= mem_wdata;
    rd_reg   <= mem_rd;
    last_reg <= mem_rdata;
  end

  // outside the answer cycle the bus toggles instead of holding
  assign mem_rdata = rd_reg ? store[mem_addr] : ~last_reg;
endmodule : io_memory_model

/* verification/io_processor_addressing_and_jump_decode_bench.sv */
`timescale 1ns/10ps

module io_processor_addressing_and_jump_decode_bench;
  import iop_pkg::*;
  typedef struct packed {logic [11:0] pc; logic [17:0] acc;} note_t;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] mem_rdata, mem_addr, mem_wdata, pc, oper_addr, oper_data;
  logic        mem_rd, mem_wr, oper_valid, hung;
  logic [17:0] acc;
  note_t       notes[$];
  note_t       ops[$];
  int          miscompares = 0;
  int          n_compared = 0;
  logic [31:0] rnd = 32'hD81A;

  always #12.5 clk = ~clk;

  io_processor_decode dut_u (.clk(clk), .rstn(rstn), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .pc(pc), .acc(acc), .oper_addr(oper_addr),
    .oper_data(oper_data), .oper_valid(oper_valid), .hung(hung));
  io_memory_model mem_u (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic put(input logic [11:0] a, input logic [11:0] w);
    mem_u.store[a] = w;
  endtask : put

  task automatic clr;
    for (int i = 0; i < 4096; i++)
      put(12'(i), 12'h000);
  endtask : clr

  // release reset, note the result, wait for the closing hang
  task automatic run(input string name, input logic [11:0] epc,
                     input logic [17:0] eacc);
    int i;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    notes.push_back('{epc, eacc});
    i = 0;
    while (hung !== 1'b1 && i < 400)
    begin
      @(negedge clk);
      i++;
    end
    if (i == 400)
    begin
      miscompares++;
      end_sim();
    end
    @(negedge clk);
    $display("test %s done", name);
    rstn = 1'b0;
  endtask : run

  // compare final pc and accumulator when the program hangs
  always @(posedge hung)
  begin : mon
    note_t n;
    @(negedge clk);
    n = notes.pop_front();
    check({6'h00, pc}, {6'h00, n.pc});
    check(acc, n.acc);
  end

  // compare each reported operand with the oldest operand note
  always @(negedge clk)
  begin : opmon
    note_t n;
    if (oper_valid === 1'b1)
    begin
      if (ops.size() == 0)
        check(18'h3FFFF, 18'h00000);
      else
      begin
        n = ops.pop_front();
        check({6'h00, oper_addr}, {6'h00, n.pc});
        check({6'h00, oper_data}, n.acc);
      end
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    logic [17:0] v;
    logic [17:0] vals [4];
    logic [5:0]  op, d1, d2, d3, s;
    logic [11:0] r1, r2;
    logic        tk;
    rnd = lfsr(rnd);
    vals = '{18'h00000, 18'h3FFFF, 18'h20000, {1'b0, rnd[16:1], 1'b1}};
    for (int k = 0; k < 16; k++)
    begin
      v = vals[k % 4];
      op = OP_ZJN + 6'(k / 4);
      clr();
      put(12'h000, {OP_LDL, v[17:12]});
      put(12'h001, v[11:0]);
      put(12'h002, {op, 6'h02});
      put(12'h003, {OP_LDI, 6'h2A});
      put(12'h004, {OP_UJN, D_ZERO});
      case (k / 4)
        0: tk = (v == 18'h00000);
        1: tk = (v != 18'h00000);
        2: tk = !v[17];
        default: tk = v[17];
      endcase
      run("cond jump", 12'h004, tk ? v : 18'h0002A);
    end
    clr();
    put(12'h000, {OP_UJN, 6'h03});
    put(12'h001, {OP_LDI, D_ONES});
    put(12'h002, {OP_UJN, D_ONES});
    put(12'h003, {OP_LDI, 6'h05});
    put(12'h004, {OP_UJN, 6'h3E});
    run("relative jump", 12'h002, 18'h00005);
    rnd = lfsr(rnd);
    v = rnd[17:0];
    d1 = rnd[23:18];
    d2 = rnd[29:24];
    s = {1'b0, rnd[4:0]};
    rnd = lfsr(rnd);
    d3 = rnd[5:0];
    clr();
    put(12'h000, {OP_LDL, v[17:12]});
    put(12'h001, v[11:0]);
    put(12'h002, {OP_LDIFF, d1});
    put(12'h003, {OP_SCLR, d2});
    put(12'h004, {OP_SHIFT, s});
    put(12'h005, {OP_SHIFT, 6'h39});
    put(12'h006, {OP_LPROD, d3});
    put(12'h007, {OP_UJN, D_ZERO});
    v[5:0] = (v[5:0] ^ d1) & ~d2;
    repeat (s) v = {v[16:0], v[17]};
    v = v >> 6;
    run("logic shift", 12'h007, {12'h000, v[5:0] & d3});
    rnd = lfsr(rnd);
    r1 = rnd[11:0];
    r2 = rnd[23:12];
    clr();
    put(12'h001, {OP_LJM, 6'h05});
    put(12'h002, 12'h100);
    put(12'h005, 12'h010);
    put(12'h006, 12'h300);
    put(12'h110, {OP_RJM, D_ZERO});
    put(12'h111, 12'h200);
    put(12'h201, 12'h806);
    put(12'h202, 12'hA05);
    put(12'h203, 12'h2F1);
    put(12'h204, {GRP_DIR, 3'h3, 6'h07});
    put(12'h205, {OP_UJN, D_ZERO});
    put(12'h007, ~r2);
    put(12'h300, r1);
    put(12'h301, r2);
    // operands reported by indirect, indexed and short direct forms
    ops.push_back('{12'h300, {6'h00, r1}});
    ops.push_back('{12'h301, {6'h00, r2}});
    ops.push_back('{12'h007, {6'h00, ~r2}});
    run("memory ref", 12'h205, {6'h00, r2});
    check({6'h00, mem_u.store[12'h200]}, 18'h00112);
    check(18'(ops.size()), 18'h00000);
    end_sim();
  end
endmodule : io_processor_addressing_and_jump_decode_bench
